// File: verilog/rtcpin_defines.svh
// Purpose: offsets, widths, reset values and timing counts for the rtc pin logic
// Assumes: 125 MHz mclk
// Notes:   definitions only
`ifndef RTCPIN_DEFINES_SVH
`define RTCPIN_DEFINES_SVH

`define RTCPIN_BUS_W          8
`define RTCPIN_RATE_W         4
`define RTCPIN_FLAG_W         8
`define RTCPIN_RAM_BASE       8'h0E
`define RTCPIN_RAM_TOP        8'h7F
`define RTCPIN_RAM_BYTES      114
`define RTCPIN_RAM_AW         7
`define RTCPIN_DIV_STAGES     15
`define RTCPIN_RATE_LUT       64'hDCBA987654321870
`define RTCPIN_ENABLE_32K_RST       1'b0
`define RTCPIN_DV1_RST        1'b0
`define RTCPIN_CLK_PERIOD_NS  8
`define RTCPIN_REC_TIME_NS    200000000
`define RTCPIN_REC_CYCLES     ((`RTCPIN_REC_TIME_NS + `RTCPIN_CLK_PERIOD_NS - 1) / `RTCPIN_CLK_PERIOD_NS)

`endif

// File: verilog/rtcpin_pkg.sv
// Purpose: types shared by the rtc pin logic
// Assumes: nothing
// Notes:   gray codes on the read path; idle to write changes both bits
package rtcpin_pkg;

   typedef enum logic [1:0] {
      RTCPIN_BUS_IDLE  = 2'b00,
      RTCPIN_BUS_READ  = 2'b01,
      RTCPIN_BUS_WRITE = 2'b11
   } rtcpin_bus_state_t;

   typedef enum logic {
      RTCPIN_CLR_IDLE  = 1'b0,
      RTCPIN_CLR_SWEEP = 1'b1
   } rtcpin_clr_state_t;

endpackage

// File: verilog/rtcpin_sqw_gen.sv
// Purpose: divider chain and tap selection for the square-wave pin
// Assumes: osc_level is the 32.768 kHz oscillator, synchronous to mclk
// Notes:   output is registered
`timescale 1ns/1ps
`include "rtcpin_defines.svh"

module rtcpin_sqw_gen
   import rtcpin_pkg::*;
#(
   parameter int                          STAGES   = `RTCPIN_DIV_STAGES,
   parameter logic [16*`RTCPIN_RATE_W-1:0] RATE_LUT = `RTCPIN_RATE_LUT
) (
   input  wire logic                       mclk,
   input  wire logic                       rst,
   input  wire logic                       osc_level,
   input  wire logic [`RTCPIN_RATE_W-1:0]  rate_sel,
   input  wire logic                       sel_32k,
   input  wire logic                       run,
   output logic                            wave
);

   logic                      osc_d_r;
   logic [STAGES-1:0]         div_r;
   logic [`RTCPIN_RATE_W-1:0] tap_idx;
   logic                      tap_bit;
   logic                      wave_nxt;

   // rate code to one divider stage, code zero gives no output
   assign tap_idx  = RATE_LUT[rate_sel*`RTCPIN_RATE_W +: `RTCPIN_RATE_W];
   assign tap_bit  = div_r[tap_idx];
   // 32 kHz overrides the rate field rate taps of the chain
   assign wave_nxt = run & (sel_32k ? osc_d_r : ((rate_sel != 4'h0) & tap_bit));

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         osc_d_r <= 1'b0;
         div_r   <= '0;
         wave    <= 1'b0;
      end else begin
         osc_d_r <= osc_level;
         if (osc_level & ~osc_d_r) begin
            div_r <= div_r + 1'b1;
         end
         wave    <= wave_nxt;
      end
   end

endmodule

// File: verilog/rtcpin_top.sv
// Purpose: pin logic of a battery-backed clock/calendar: host bus, square wave, irq, power-on, ram clear
// Assumes: all pin inputs synchronous to mclk; supply state given as levels
// Notes:   open-drain pins drive low while their enable is high
`timescale 1ns/1ps
`include "rtcpin_defines.svh"

module rtcpin_top
   import rtcpin_pkg::*;
#(
   parameter int                          REC_CYCLES = `RTCPIN_REC_CYCLES,
   parameter int                          RAM_BYTES  = `RTCPIN_RAM_BYTES,
   parameter logic [16*`RTCPIN_RATE_W-1:0] RATE_LUT   = `RTCPIN_RATE_LUT
) (
   input  wire logic                       mclk,
   input  wire logic                       rst,
   input  wire logic [`RTCPIN_BUS_W-1:0]   muxed_addr_data_bus_in,
   output logic      [`RTCPIN_BUS_W-1:0]   muxed_addr_data_bus_out,
   output logic                            muxed_addr_data_bus_oe,
   input  wire logic                       addr_strobe,
   input  wire logic                       chip_sel_n,
   input  wire logic                       read_strobe_n,
   input  wire logic                       write_strobe_n,
   output logic      [`RTCPIN_BUS_W-1:0]   ext_addr,
   output logic      [`RTCPIN_BUS_W-1:0]   ext_wdata,
   output logic                            ext_wr,
   input  wire logic [`RTCPIN_BUS_W-1:0]   ext_rdata,
   input  wire logic                       main_supply_ok,
   input  wire logic                       aux_battery_supply,
   input  wire logic                       aux_battery_enable,
   input  wire logic                       osc_level,
   input  wire logic [`RTCPIN_RATE_W-1:0]  rate_sel,
   input  wire logic                       square_wave_enable,
   input  wire logic                       ctl_wr,
   input  wire logic                       ctl_enable_32k,
   input  wire logic                       ctl_divider_ctrl_bit1,
   output logic                            enable_32k,
   output logic                            divider_ctrl_bit1,
   output logic                            recovered,
   output logic                            square_wave_out,
   input  wire logic [`RTCPIN_FLAG_W-1:0]  irq_flags,
   input  wire logic [`RTCPIN_FLAG_W-1:0]  irq_enables,
   output logic                            irq_n_out,
   output logic                            irq_n_oe,
   input  wire logic                       wake_key_n,
   input  wire logic                       wake_alarm,
   output logic                            wake_key_event,
   input  wire logic                       pwr_ctl_wr,
   input  wire logic                       pwr_ctl_on,
   output logic                            power_on_n_out,
   output logic                            power_on_n_oe,
   input  wire logic                       ram_clear_n,
   input  wire logic                       ram_clear_enable,
   output logic                            ram_clear_busy
);

   localparam int REC_W = $clog2(REC_CYCLES + 1);

   rtcpin_bus_state_t         bus_st_r;
   rtcpin_bus_state_t         bus_st_nxt;
   rtcpin_clr_state_t         clr_st_r;
   logic [`RTCPIN_BUS_W-1:0]  ram_r [0:RAM_BYTES-1];
   logic [`RTCPIN_RAM_AW-1:0] clr_idx_r;
   logic [`RTCPIN_BUS_W-1:0]  addr_r;
   logic [`RTCPIN_BUS_W-1:0]  wdata_r;
   logic                      ale_d_r;
   logic                      key_d_r;
   logic                      ram_clear_n_d_r;
   logic                      vcc_d_r;
   logic [REC_W-1:0]          rec_cnt_r;
   logic                      ram_wr_r;

   // decode
   logic                      ale_fall;
   logic                      key_fall;
   logic                      ram_clear_n_fall;
   logic                      vcc_rise;
   logic                      access_ok;
   logic                      rd_act;
   logic                      wr_act;
   logic                      in_ram;
   logic [`RTCPIN_BUS_W-1:0]  ram_off;
   logic [`RTCPIN_BUS_W-1:0]  rd_data;
   logic                      wr_commit;
   logic                      aux_ok;
   logic                      pwr_set;
   logic                      irq_hit;
   logic                      sq_run;
   logic                      sq_sel32;

   assign ale_fall  = ale_d_r & ~addr_strobe;
   assign key_fall  = key_d_r & ~wake_key_n;
   assign ram_clear_n_fall = ram_clear_n_d_r & ~ram_clear_n;
   assign vcc_rise  = main_supply_ok & ~vcc_d_r;
   assign aux_ok    = aux_battery_supply & aux_battery_enable;
   // bus ignored below power-fail and until recovery ends
   assign access_ok = main_supply_ok & recovered;
   // select must cover the strobe no transfer without select
   assign rd_act    = access_ok & ~chip_sel_n & ~read_strobe_n;
   assign wr_act    = access_ok & ~chip_sel_n & ~write_strobe_n;
   assign in_ram    = (addr_r >= `RTCPIN_RAM_BASE) && (addr_r <= `RTCPIN_RAM_TOP);
   assign ram_off   = addr_r - `RTCPIN_RAM_BASE;
   assign rd_data   = in_ram ? ram_r[ram_off[`RTCPIN_RAM_AW-1:0]] : ext_rdata;
   // store the data held in the latter part of the strobe
   assign wr_commit = (bus_st_r == RTCPIN_BUS_WRITE) & ~wr_act;
   assign pwr_set   = ~main_supply_ok & aux_ok & (key_fall | wake_alarm);
   assign irq_hit   = |(irq_flags & irq_enables);
   // with supply, on after recovery when either enable is set; on battery only enable_32k with aux_ok runs it
   assign sq_run    = main_supply_ok ? (recovered & (square_wave_enable | enable_32k))
                                     : (enable_32k & aux_ok);
   assign sq_sel32  = enable_32k | ~main_supply_ok;

   always_comb begin
      bus_st_nxt = bus_st_r;
      case (bus_st_r)
         RTCPIN_BUS_IDLE: begin
            if (rd_act) begin
               bus_st_nxt = RTCPIN_BUS_READ;
            end else if (wr_act) begin
               bus_st_nxt = RTCPIN_BUS_WRITE;
            end
         end
         RTCPIN_BUS_READ: begin
            if (!rd_act) begin
               bus_st_nxt = RTCPIN_BUS_IDLE;
            end
         end
         RTCPIN_BUS_WRITE: begin
            if (!wr_act) begin
               bus_st_nxt = RTCPIN_BUS_IDLE;
            end
         end
         default: bus_st_nxt = RTCPIN_BUS_IDLE;
      endcase
   end

   // edge detect and supply tracking
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ale_d_r  <= 1'b0;
         key_d_r  <= 1'b1;
         ram_clear_n_d_r <= 1'b1;
         vcc_d_r  <= 1'b0;
      end else begin
         ale_d_r  <= addr_strobe;
         key_d_r  <= wake_key_n;
         ram_clear_n_d_r <= ram_clear_n;
         vcc_d_r  <= main_supply_ok;
      end
   end

   // recovery timer after supply returns
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rec_cnt_r <= '0;
         recovered <= 1'b0;
      end else if (!main_supply_ok) begin
         rec_cnt_r <= '0;
         recovered <= 1'b0;
      end else if (!recovered) begin
         rec_cnt_r <= rec_cnt_r + 1'b1;
         recovered <= (rec_cnt_r == REC_W'(REC_CYCLES - 1));
      end
   end

   // power-up sets both bits, winning over a software write
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         enable_32k        <= `RTCPIN_ENABLE_32K_RST;
         divider_ctrl_bit1 <= `RTCPIN_DV1_RST;
      end else if (vcc_rise) begin
         enable_32k        <= 1'b1;
         divider_ctrl_bit1 <= 1'b1;
      end else if (ctl_wr && access_ok) begin
         enable_32k        <= ctl_enable_32k;
         divider_ctrl_bit1 <= ctl_divider_ctrl_bit1;
      end
   end

   // address latch on strobe fall, selected or not
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         addr_r <= '0;
      end else if (ale_fall && main_supply_ok) begin
         addr_r <= muxed_addr_data_bus_in;
      end
   end

   // bus cycle: data sampled through the write strobe, committed at its end
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         bus_st_r  <= RTCPIN_BUS_IDLE;
         wdata_r   <= '0;
         ext_addr  <= '0;
         ext_wdata <= '0;
         ext_wr    <= 1'b0;
         ram_wr_r  <= 1'b0;
      end else begin
         bus_st_r  <= bus_st_nxt;
         if (wr_act) begin
            wdata_r <= muxed_addr_data_bus_in;
         end
         ext_addr  <= addr_r;
         ext_wdata <= wdata_r;
         ext_wr    <= wr_commit & ~in_ram;
         ram_wr_r  <= wr_commit & in_ram;
      end
   end

   // read drive while strobe low, float when it rises
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         muxed_addr_data_bus_out <= '0;
         muxed_addr_data_bus_oe  <= 1'b0;
      end else begin
         muxed_addr_data_bus_out <= rd_act ? rd_data : '0;
         muxed_addr_data_bus_oe  <= rd_act;
      end
   end

   // user ram with sweep clear; clear takes priority over a host write
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         clr_st_r  <= RTCPIN_CLR_IDLE;
         clr_idx_r <= '0;
      end else begin
         case (clr_st_r)
            RTCPIN_CLR_IDLE: begin
               if (ram_clear_n_fall && ram_clear_enable) begin
                  clr_st_r  <= RTCPIN_CLR_SWEEP;
                  clr_idx_r <= '0;
               end
            end
            RTCPIN_CLR_SWEEP: begin
               clr_idx_r <= clr_idx_r + 1'b1;
               if (clr_idx_r == `RTCPIN_RAM_AW'(RAM_BYTES - 1)) begin
                  clr_st_r <= RTCPIN_CLR_IDLE;
               end
            end
            default: clr_st_r <= RTCPIN_CLR_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (clr_st_r == RTCPIN_CLR_SWEEP) begin
         ram_r[clr_idx_r] <= '0;
      end else if (ram_wr_r) begin
         ram_r[ext_addr[`RTCPIN_RAM_AW-1:0] - `RTCPIN_RAM_AW'(`RTCPIN_RAM_BASE)] <= ext_wdata;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ram_clear_busy <= 1'b0;
      end else begin
         ram_clear_busy <= (clr_st_r == RTCPIN_CLR_SWEEP) | (ram_clear_n_fall & ram_clear_enable);
      end
   end

   // interrupt pin pulls low only while an enabled flag is set
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         irq_n_out <= 1'b0;
         irq_n_oe  <= 1'b0;
      end else begin
         irq_n_out <= 1'b0;
         irq_n_oe  <= main_supply_ok & irq_hit;
      end
   end

   // key as interrupt source while powered
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         wake_key_event <= 1'b0;
      end else begin
         wake_key_event <= main_supply_ok & key_fall;
      end
   end

   // power-on: wake sets it without supply software owns it when powered
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         power_on_n_out <= 1'b0;
         power_on_n_oe  <= 1'b0;
      end else begin
         power_on_n_out <= 1'b0;
         if (pwr_set) begin
            power_on_n_oe <= 1'b1;
         end else if (pwr_ctl_wr && access_ok) begin
            power_on_n_oe <= pwr_ctl_on;
         end
      end
   end

   rtcpin_sqw_gen #(
      .STAGES   (`RTCPIN_DIV_STAGES),
      .RATE_LUT (RATE_LUT)
   ) i_rtcpin_sqw_gen (
      .mclk     (mclk),
      .rst      (rst),
      .osc_level(osc_level),
      .rate_sel (rate_sel),
      .sel_32k  (sq_sel32),
      .run      (sq_run),
      .wave     (square_wave_out)
   );

endmodule

// File: sim/rtcpin_top_chk.sv
// Purpose: port assertions for rtcpin_top
// Assumes: one mclk domain
// Notes:   bound after the module
`timescale 1ns/1ps
module rtcpin_top_chk (
   input wire logic       mclk,
   input wire logic       rst,
   input wire logic       muxed_addr_data_bus_oe,
   input wire logic       chip_sel_n,
   input wire logic       read_strobe_n,
   input wire logic       main_supply_ok,
   input wire logic       recovered,
   input wire logic [7:0] irq_flags,
   input wire logic [7:0] irq_enables,
   input wire logic       irq_n_out,
   input wire logic       irq_n_oe,
   input wire logic       square_wave_enable,
   input wire logic       enable_32k,
   input wire logic       divider_ctrl_bit1,
   input wire logic       square_wave_out,
   input wire logic       osc_level,
   input wire logic       aux_battery_supply,
   input wire logic       aux_battery_enable,
   input wire logic       wake_alarm,
   input wire logic       power_on_n_oe
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   wire logic irq_act = |(irq_flags & irq_enables);
   property p_rd_drive; (!chip_sel_n && !read_strobe_n && main_supply_ok && recovered) |=> muxed_addr_data_bus_oe; endproperty
   a_rd_drive: assert property (p_rd_drive) else $error("bus not driven in read");
   property p_rd_release; $rose(read_strobe_n) |=> !muxed_addr_data_bus_oe; endproperty
   a_rd_release: assert property (p_rd_release) else $error("bus held after read");
   property p_irq_on; (main_supply_ok && irq_act) |=> irq_n_oe; endproperty
   a_irq_on: assert property (p_irq_on) else $error("irq not pulled low");
   property p_irq_off; !irq_act |=> (!irq_n_oe && !irq_n_out); endproperty
   a_irq_off: assert property (p_irq_off) else $error("irq not floating");
   property p_sqw_off; (!square_wave_enable && !enable_32k) |=> !square_wave_out; endproperty
   a_sqw_off: assert property (p_sqw_off) else $error("square wave not off");
   property p_32k; (enable_32k && main_supply_ok && $past(main_supply_ok) && recovered) |=> square_wave_out == $past(osc_level, 2); endproperty
   a_32k: assert property (p_32k) else $error("32k output not oscillator");
   property p_pwrup; $rose(main_supply_ok) |-> ##[1:3] (enable_32k && divider_ctrl_bit1); endproperty
   a_pwrup: assert property (p_pwrup) else $error("power-up bits not set");
   property p_dead; !main_supply_ok |=> (!muxed_addr_data_bus_oe && !irq_n_oe); endproperty
   a_dead: assert property (p_dead) else $error("output active below supply");
   property p_wake; (!main_supply_ok && aux_battery_supply && aux_battery_enable && wake_alarm) |=> power_on_n_oe; endproperty
   a_wake: assert property (p_wake) else $error("wake-up did not assert power-on");
   c_read: cover property (muxed_addr_data_bus_oe);
   c_irq: cover property ($rose(irq_n_oe));
   c_pwr: cover property ($rose(power_on_n_oe));
endmodule
bind rtcpin_top rtcpin_top_chk i_rtcpin_top_chk (.*);

// File: sim/rtcpin_host_model.sv
// Purpose: host processor on the multiplexed bus
// Assumes: device outputs registered on mclk
// Notes:   released lines toggle so stale data never matches
`timescale 1ns/1ps
module rtcpin_host_model (
   input  wire logic       mclk,
   input  wire logic [7:0] muxed_addr_data_bus_out,
   input  wire logic       muxed_addr_data_bus_oe,
   output logic      [7:0] muxed_addr_data_bus_in,
   output logic            addr_strobe,
   output logic            chip_sel_n,
   output logic            read_strobe_n,
   output logic            write_strobe_n
);
   logic [7:0] hv, last;
   logic       hen;
   assign muxed_addr_data_bus_in = muxed_addr_data_bus_oe ? muxed_addr_data_bus_out : (hen ? hv : ~last);
   initial begin
      {hen, hv, last, addr_strobe} = 0;
      {chip_sel_n, read_strobe_n, write_strobe_n} = 3'h7;
   end
   always @(posedge mclk) last <= muxed_addr_data_bus_in;
   task automatic step(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic latch(input logic [7:0] a);
      hv = a;
      hen = 1;
      addr_strobe = 1;
      step(1);
      addr_strobe = 0;
      step(1);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] dt, input logic sel);
      latch(a);
      chip_sel_n = !sel;
      write_strobe_n = 0;
      hv = dt;
      step(3);
      write_strobe_n = 1;
      chip_sel_n = 1;
      hen = 0;
      step(4);
   endtask
   task automatic rd(input logic [7:0] a, input logic sel, output logic [7:0] dt, output logic o, output logic r);
      latch(a);
      hen = 0;
      chip_sel_n = !sel;
      read_strobe_n = 0;
      repeat (3) @(posedge mclk);
      dt = muxed_addr_data_bus_in;
      o = muxed_addr_data_bus_oe;
      #1;
      read_strobe_n = 1;
      chip_sel_n = 1;
      step(2);
      r = muxed_addr_data_bus_oe;
      step(1);
   endtask
endmodule

// File: sim/test_rtc_pin_interface_logic.sv
// Purpose: directed tests of rtcpin_top through its pins
// Assumes: oscillator modelled as 16 mclk period
// Notes:   recovery shortened to 10 cycles
`timescale 1ns/1ps
`include "rtcpin_defines.svh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin miscompares++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module test_rtc_pin_interface_logic;
   logic       mclk, rst, addr_strobe, chip_sel_n, read_strobe_n, write_strobe_n, muxed_addr_data_bus_oe;
   logic [7:0] muxed_addr_data_bus_in, muxed_addr_data_bus_out, ext_addr, ext_wdata, ext_rdata, irq_flags, irq_enables;
   logic       ext_wr, main_supply_ok, aux_battery_supply, aux_battery_enable, osc_level, square_wave_enable, ctl_wr;
   logic       ctl_enable_32k, ctl_divider_ctrl_bit1, enable_32k, divider_ctrl_bit1, recovered, square_wave_out;
   logic       irq_n_out, irq_n_oe, wake_key_n, wake_alarm, wake_key_event, pwr_ctl_wr, pwr_ctl_on;
   logic       power_on_n_out, power_on_n_oe, ram_clear_n, ram_clear_enable, ram_clear_busy, o, r;
   logic [3:0] rate_sel;
   logic [7:0] d, ew_a, ew_d;
   int         miscompares, total_checks, cyc, ew_n, ke_n, p, n, s;
   assign ext_rdata = ~ext_addr;
   rtcpin_top #(.REC_CYCLES(10)) i_rtcpin_top (.*);
   rtcpin_host_model i_rtcpin_host_model (.*);
   initial begin
      mclk = 0;
      forever #4 mclk = ~mclk;
   end
   initial begin
      osc_level = 0;
      forever begin
         repeat (8) @(posedge mclk);
         #1 osc_level = ~osc_level;
      end
   end
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (ext_wr === 1'b1) begin
         ew_n <= ew_n + 1;
         ew_a <= ext_addr;
         ew_d <= ext_wdata;
      end
      if (wake_key_event === 1'b1) ke_n <= ke_n + 1;
   end
   task automatic step(input int k);
      repeat (k) @(posedge mclk);
      #1;
   endtask
   task automatic waitr();
      step(2);
      for (int k = 0; k < 100 && recovered !== 1'b1; k++) step(1);
   endtask
   task automatic rise();
      logic l;
      l = square_wave_out;
      for (int k = 0; k < 20000; k++) begin
         step(1);
         if (l === 1'b0 && square_wave_out === 1'b1) break;
         l = square_wave_out;
      end
   endtask
   task automatic per();
      int t;
      rise();
      rise();
      t = cyc;
      rise();
      p = cyc - t;
   endtask
   task automatic highs();
      n = 0;
      repeat (40) begin
         step(1);
         n += square_wave_out;
      end
   endtask
   task automatic ctl(input logic e);
      ctl_enable_32k = e;
      ctl_divider_ctrl_bit1 = 1;
      ctl_wr = 1;
      step(1);
      ctl_wr = 0;
      step(1);
   endtask
   task automatic pwr_off();
      pwr_ctl_on = 0;
      pwr_ctl_wr = 1;
      step(1);
      pwr_ctl_wr = 0;
      step(2);
   endtask
   task automatic key();
      wake_key_n = 0;
      step(3);
      wake_key_n = 1;
      step(2);
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      #640000;
      miscompares++;
      test_done();
   end
   initial begin
      {ctl_wr, ctl_enable_32k, ctl_divider_ctrl_bit1, square_wave_enable, wake_alarm, pwr_ctl_wr, pwr_ctl_on} = 0;
      {aux_battery_supply, aux_battery_enable, ram_clear_enable, irq_flags, irq_enables, rate_sel} = 0;
      {wake_key_n, ram_clear_n, rst, main_supply_ok} = 4'hF;
      repeat (10) @(posedge mclk);
      #1 rst = 0;
      i_rtcpin_host_model.rd(8'h0E, 1, d, o, r);
      `CHK("oe_rec", 1'b0, o)
      step(1);
      `CHK("rec_lo", 1'b0, recovered)
      step(1);
      `CHK("rec_hi", 1'b1, recovered)
      `CHK("enable_32k", 1'b1, enable_32k)
      `CHK("dv1", 1'b1, divider_ctrl_bit1)
      per();
      `CHK("p32k", 16, p)
      i_rtcpin_host_model.wr(8'h0E, 8'hA5, 1);
      i_rtcpin_host_model.wr(8'h7F, 8'h3C, 1);
      i_rtcpin_host_model.wr(8'h20, 8'h11, 1);
      i_rtcpin_host_model.wr(8'h20, 8'h99, 0);
      i_rtcpin_host_model.rd(8'h0E, 1, d, o, r);
      `CHK("rd0e", 8'hA5, d)
      `CHK("oe", 1'b1, o)
      `CHK("rel", 1'b0, r)
      i_rtcpin_host_model.rd(8'h7F, 1, d, o, r);
      `CHK("rd7f", 8'h3C, d)
      i_rtcpin_host_model.rd(8'h20, 1, d, o, r);
      `CHK("rd20", 8'h11, d)
      i_rtcpin_host_model.rd(8'h0E, 0, d, o, r);
      `CHK("oe_nosel", 1'b0, o)
      i_rtcpin_host_model.wr(8'h0A, 8'h5A, 1);
      `CHK("ewn", 1, ew_n)
      `CHK("ewa", 8'h0A, ew_a)
      `CHK("ewd", 8'h5A, ew_d)
      i_rtcpin_host_model.wr(8'h80, 8'hC3, 1);
      `CHK("ewa80", 8'h80, ew_a)
      i_rtcpin_host_model.rd(8'h0D, 1, d, o, r);
      `CHK("rd0d", 8'hF2, d)
      irq_flags = 8'h04;
      step(2);
      `CHK("irq_mask", 1'b0, irq_n_oe)
      irq_enables = 8'h0C;
      step(2);
      `CHK("irq_on", 1'b1, irq_n_oe)
      `CHK("irq_out", 1'b0, irq_n_out)
      irq_flags = 8'h00;
      step(2);
      `CHK("irq_clr", 1'b0, irq_n_oe)
      ctl(0);
      highs();
      `CHK("sqw_off", 0, n)
      square_wave_enable = 1;
      for (int c = 1; c < 9; c++) begin
         rate_sel = 4'(c);
         s = int'((`RTCPIN_RATE_LUT >> (4 * c)) & 64'hF);
         per();
         `CHK("period", 16 << (s + 1), p)
      end
      rate_sel = 0;
      highs();
      `CHK("rate0", 0, n)
      ram_clear_enable = 1;
      ram_clear_n = 0;
      step(1);
      ram_clear_n = 1;
      n = 0;
      repeat (300) begin
         step(1);
         n += ram_clear_busy;
      end
      `CHK("clr_len", 114, n)
      i_rtcpin_host_model.rd(8'h7F, 1, d, o, r);
      `CHK("clr7f", 8'h00, d)
      i_rtcpin_host_model.rd(8'h0E, 1, d, o, r);
      `CHK("clr0e", 8'h00, d)
      ctl(1);
      {aux_battery_supply, aux_battery_enable, irq_flags} = {2'b11, 8'h04};
      main_supply_ok = 0;
      step(2);
      per();
      `CHK("p_aux", 16, p)
      i_rtcpin_host_model.rd(8'h0E, 1, d, o, r);
      `CHK("oe_dead", 1'b0, o)
      `CHK("irq_dead", 1'b0, irq_n_oe)
      wake_alarm = 1;
      step(2);
      `CHK("pwr_wake", 1'b1, power_on_n_oe)
      `CHK("pwr_out", 1'b0, power_on_n_out)
      wake_alarm = 0;
      main_supply_ok = 1;
      waitr();
      pwr_off();
      `CHK("pwr_sw", 1'b0, power_on_n_oe)
      main_supply_ok = 0;
      aux_battery_enable = 0;
      key();
      `CHK("key_noabe", 1'b0, power_on_n_oe)
      aux_battery_enable = 1;
      key();
      `CHK("key_pwr", 1'b1, power_on_n_oe)
      main_supply_ok = 1;
      waitr();
      pwr_off();
      key();
      `CHK("key_evt", 1, ke_n)
      `CHK("key_nopwr", 1'b0, power_on_n_oe)
      test_done();
   end
endmodule
